// *** core/rsi_reset_init.sv ***
// Reset state initializer with AXI4-Lite register access
`timescale 1ns/100ps
module rsi_reset_init #(
  parameter logic [15:0] WDT_LIMIT = rsi_pkg::WDT_LIMIT_DEF
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cen,
  input  wire logic        external_reset_pin_n,
  input  wire logic        low_voltage_reset,
  input  wire logic        usb_reset,
  input  wire logic        core_halted,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq,
  output logic             core_restart,
  output logic             timers_on
);
  import rsi_pkg::*;

  // ****************************************************************
  // Input synchronisers and event detection
  // ****************************************************************
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic [2:0] sync3_reg;
  logic       ev_pin;
  logic       ev_lvr;
  logic       ev_usb;
  logic       ev_wdt;
  logic       fire;
  rsi_col_e   col;
  logic [15:0] wdt_count_reg;
  logic [7:0]  ctrl_reg;

  // Three-stage capture of pin, low-voltage and USB indications
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 3'h1; // Pin idles high, no false edge after reset
      sync2_reg <= 3'h1;
      sync3_reg <= 3'h1;
    end else if (cen) begin
      sync1_reg <= {usb_reset, low_voltage_reset, external_reset_pin_n};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign ev_pin = ~sync2_reg[0] & sync3_reg[0];
  assign ev_lvr = sync2_reg[1] & ~sync3_reg[1];
  assign ev_usb = sync2_reg[2] & ~sync3_reg[2];
  assign ev_wdt = ctrl_reg[BIT_WDT_EN] & (wdt_count_reg == WDT_LIMIT);
  assign fire   = cen & (ev_pin | ev_lvr | ev_usb | ev_wdt);

  // Column choice: pin, then low-voltage, then USB, then watchdog
  always_comb begin
    col = COL_EXT_RUN;
    if (ev_pin | ev_lvr) begin
      col = core_halted ? COL_EXT_HALT : COL_EXT_RUN;
    end else if (ev_usb) begin
      col = COL_EXT_RUN;
    end else if (ev_wdt) begin
      col = core_halted ? COL_WDT_HALT : COL_WDT_RUN;
    end
  end

  // ****************************************************************
  // Bus write path
  // ****************************************************************
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        wr_do;
  logic        wr_hit;
  logic [3:0]  wr_idx;
  logic        wr_sfr;

  assign wr_do  = cen & aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_sfr = aw_addr_reg[7:6] == OFS_SFR_BASE[7:6];
  assign wr_idx = aw_addr_reg[5:2];
  assign wr_hit = wr_sfr | (aw_addr_reg == OFS_STATUS) | (aw_addr_reg == OFS_CTRL)
                | (aw_addr_reg == OFS_WDT) | (aw_addr_reg == OFS_STACK)
                | (aw_addr_reg == OFS_IRQ_STAT) | (aw_addr_reg == OFS_IRQ_MASK)
                | (aw_addr_reg == OFS_RECORD);

  // Address and data taken in either order, held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (cen) begin
      s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
      end
    end
  end

  logic wr_lane0;
  assign wr_lane0 = wr_do & w_strb_reg[0];

  // ****************************************************************
  // Status flags, control, record and stack pointer
  // ****************************************************************
  logic     to_flag_reg;
  logic     pdf_flag_reg;
  logic     low_voltage_reset_flag_reg;
  logic [3:0] sp_reg;
  rsi_col_e last_col_reg;
  logic [3:0] last_src_reg;
  logic     last_halt_reg;

  // Time-out and power-down flags per column
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      to_flag_reg  <= 1'b0;
      pdf_flag_reg <= 1'b0;
    end else if (fire) begin
      case (col)
        COL_WDT_RUN: begin
          to_flag_reg <= 1'b1;
        end
        COL_WDT_HALT: begin
          to_flag_reg  <= 1'b1;
          pdf_flag_reg <= 1'b1;
        end
        COL_EXT_HALT: begin
          to_flag_reg  <= 1'b0;
          pdf_flag_reg <= 1'b1;
        end
        default: begin
          to_flag_reg  <= to_flag_reg;
          pdf_flag_reg <= pdf_flag_reg;
        end
      endcase
    end
  end

  // Low-voltage flag: set by hardware, cleared by writing zero; set wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_voltage_reset_flag_reg <= 1'b0;
    end else if (cen & ev_lvr) begin
      low_voltage_reset_flag_reg <= 1'b1;
    end else if (wr_lane0 & (aw_addr_reg == OFS_CTRL) & ~w_data_reg[BIT_LOW_VOLTAGE_RESET_FLAG]) begin
      low_voltage_reset_flag_reg <= 1'b0;
    end
  end

  // Control: timers and watchdog enable; reset turns timers off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= 8'h04;
    end else if (fire) begin
      ctrl_reg[BIT_TIMERS] <= 1'b0;
    end else if (wr_lane0 & (aw_addr_reg == OFS_CTRL)) begin
      ctrl_reg <= {5'h00, w_data_reg[BIT_WDT_EN:BIT_TIMERS], 1'b0};
    end
  end

  // Watchdog counter: cleared by reset or kick, then counts on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wdt_count_reg <= 16'h0000;
    end else if (fire) begin
      wdt_count_reg <= 16'h0000;
    end else if (wr_do & (aw_addr_reg == OFS_WDT)) begin
      wdt_count_reg <= 16'h0000;
    end else if (cen & ctrl_reg[BIT_WDT_EN]) begin
      wdt_count_reg <= wdt_count_reg + 16'h0001;
    end
  end

  // Stack pointer and record of the last reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sp_reg        <= STACK_TOP;
      last_col_reg  <= COL_POR;
      last_src_reg  <= 4'h0;
      last_halt_reg <= 1'b0;
    end else if (fire) begin
      sp_reg        <= STACK_TOP;
      last_col_reg  <= col;
      last_src_reg  <= {ev_wdt, ev_usb, ev_lvr, ev_pin};
      last_halt_reg <= core_halted;
    end else if (wr_lane0 & (aw_addr_reg == OFS_STACK)) begin
      sp_reg <= w_data_reg[3:0];
    end
  end

  // ****************************************************************
  // Special function registers
  // ****************************************************************
  logic [7:0] sfr_reg [SFR_N];
  logic [7:0] analog_sel_reg;

  // Image load per column; software writes lower priority
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < SFR_N; i++) begin
        sfr_reg[i] <= SFR_PRESET[i];
      end
    end else if (fire) begin
      for (int i = 0; i < SFR_N; i++) begin
        if (SFR_PRESET_EN[i] && col != COL_WDT_HALT) begin
          sfr_reg[i] <= SFR_PRESET[i];
        end
      end
      sfr_reg[IDX_PCL] <= 8'h00;
    end else if (wr_lane0 & wr_sfr) begin
      sfr_reg[wr_idx] <= w_data_reg[7:0] & SFR_MASK[wr_idx];
    end
  end

  // Analog pins return to converter input on every reset except watchdog-halt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      analog_sel_reg <= ANALOG_ALL;
    end else if (fire & (col != COL_WDT_HALT)) begin
      analog_sel_reg <= ANALOG_ALL;
    end
  end

  // ****************************************************************
  // Interrupt status and mask
  // ****************************************************************
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;

  assign irq_set = cen ? {ev_wdt, ev_usb, ev_lvr, ev_pin} : 4'h0;
  assign irq_clr = (wr_lane0 & (aw_addr_reg == OFS_IRQ_STAT)) ? w_data_reg[3:0] : 4'h0;

  // Sticky bits, write one to clear, set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_reg <= 4'h0;
      irq_mask_reg <= 4'h0;
      irq          <= 1'b0;
    end else if (cen) begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_lane0 & (aw_addr_reg == OFS_IRQ_MASK)) begin
        irq_mask_reg <= w_data_reg[3:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Core restart pulse and timer enable output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_restart <= 1'b0;
      timers_on    <= 1'b0;
    end else if (cen) begin
      core_restart <= fire;
      timers_on    <= ctrl_reg[BIT_TIMERS] & ~fire;
    end
  end

  // ****************************************************************
  // Bus read path
  // ****************************************************************
  logic [31:0] rd_data;
  logic        rd_hit;
  logic [7:0]  ra;

  assign ra = {s_axi_araddr[7:2], 2'h0};

  // Read multiplexer
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (ra[7:6] == OFS_SFR_BASE[7:6]) begin
      rd_data = {24'h0, sfr_reg[ra[5:2]]};
    end else begin
      case (ra)
        OFS_STATUS:   rd_data = {30'h0, pdf_flag_reg, to_flag_reg};
        OFS_CTRL:     rd_data = {24'h0, ctrl_reg[7:1], low_voltage_reset_flag_reg};
        OFS_WDT:      rd_data = {16'h0, wdt_count_reg};
        OFS_STACK:    rd_data = {28'h0, sp_reg};
        OFS_IRQ_STAT: rd_data = {28'h0, irq_stat_reg};
        OFS_IRQ_MASK: rd_data = {28'h0, irq_mask_reg};
        OFS_RECORD:   rd_data = {16'h0, analog_sel_reg, last_halt_reg,
                                 last_col_reg, last_src_reg};
        default:      rd_hit  = 1'b0;
      endcase
    end
  end

  // One read at a time, answered the cycle after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (cen) begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_data;
        s_axi_rresp  <= rd_hit ? 2'h0 : 2'h2;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_por_flags;
    @(posedge aclk) !aresetn |=> (!to_flag_reg && !pdf_flag_reg);
  endproperty
  a_por_flags: assert property (p_por_flags) else $error("flags not cleared by power-on");
  property p_run_keep;
    @(posedge aclk) disable iff (!aresetn)
      (fire && col == COL_EXT_RUN) |=> $stable({to_flag_reg, pdf_flag_reg});
  endproperty
  a_run_keep: assert property (p_run_keep) else $error("flags changed by running reset");
  property p_wdt_run;
    @(posedge aclk) disable iff (!aresetn)
      (fire && col == COL_WDT_RUN) |=> (to_flag_reg && $stable(pdf_flag_reg));
  endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("watchdog running reset flags wrong");
  property p_wdt_halt;
    @(posedge aclk) disable iff (!aresetn)
      (fire && col == COL_WDT_HALT) |=> (to_flag_reg && pdf_flag_reg && $stable(sfr_reg[IDX_PA]));
  endproperty
  a_wdt_halt: assert property (p_wdt_halt) else $error("watchdog halt reset state wrong");
  property p_ext_halt;
    @(posedge aclk) disable iff (!aresetn)
      (fire && col == COL_EXT_HALT) |=> (!to_flag_reg && pdf_flag_reg);
  endproperty
  a_ext_halt: assert property (p_ext_halt) else $error("halted pin reset flags wrong");
  property p_wdt_clear;
    @(posedge aclk) disable iff (!aresetn)
      fire |=> (wdt_count_reg == 16'h0000) ##1 (!cen || !ctrl_reg[BIT_WDT_EN] || wdt_count_reg != 16'h0000);
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("watchdog not restarted");
  property p_pcl_sp;
    @(posedge aclk) disable iff (!aresetn)
      fire |=> (sfr_reg[IDX_PCL] == 8'h00 && sp_reg == STACK_TOP);
  endproperty
  a_pcl_sp: assert property (p_pcl_sp) else $error("counter or stack not reset");
  property p_preset;
    @(posedge aclk) disable iff (!aresetn)
      (fire && col != COL_WDT_HALT) |=> (sfr_reg[IDX_PA] == 8'hff && sfr_reg[IDX_INTERRUPT_CONTROL_ZERO] == 8'h00);
  endproperty
  a_preset: assert property (p_preset) else $error("ports or interrupts not preset");
  property p_timers_off;
    @(posedge aclk) disable iff (!aresetn)
      fire |=> (!ctrl_reg[BIT_TIMERS]) ##1 !timers_on;
  endproperty
  a_timers_off: assert property (p_timers_off) else $error("timers left on");
  property p_low_voltage_reset_flag;
    @(posedge aclk) disable iff (!aresetn)
      (cen && ev_lvr) |=> low_voltage_reset_flag_reg;
  endproperty
  a_low_voltage_reset_flag: assert property (p_low_voltage_reset_flag) else $error("low-voltage flag not set");
endmodule : rsi_reset_init

// *** core/rsi_pkg.sv ***
// Constants, register map and reset images of the reset state initializer
// Summary of operation
// - Power-on reset clears time-out and power-down flags
// - Pin, low-voltage, USB reset while running: flags kept
// - Watchdog reset while running sets time-out flag
// - Watchdog reset while halted sets both flags
// - Reset disables every interrupt source, except watchdog-halt reset
// - Reset clears watchdog counter, counting restarts immediately
// - Reset switches off all timer modules
// - Ports become inputs, analog pins to converter, except watchdog-halt
// - Reset sets stack pointer to stack top
// - Port data and direction preset, except watchdog-halt
// - Every reset clears program counter low byte
// - Pin reset halted loads 01, watchdog-halt 11
// - Interrupt registers cleared, except watchdog-halt reset
// - Accumulator, table registers kept; pointers undefined
// - Mode register 03, bank pointer 00, except watchdog-halt
// - USB reset acts as running pin reset
// - Low-voltage reset sets flag; software clears it
package rsi_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS   = 8'h00;
  localparam logic [7:0] OFS_CTRL     = 8'h04;
  localparam logic [7:0] OFS_WDT      = 8'h08;
  localparam logic [7:0] OFS_STACK    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_RECORD   = 8'h18;
  localparam logic [7:0] OFS_SFR_BASE = 8'h40;

  // ****************************************************************
  // Special function register file: index, implemented bits, preset
  // ****************************************************************
  localparam int SFR_N = 16;
  localparam logic [3:0] IDX_PCL = 4'h0;
  localparam logic [3:0] IDX_PA  = 4'hc;
  localparam logic [3:0] IDX_INTERRUPT_CONTROL_ZERO = 4'ha;
  // Order: pcl mp0 mp1 acc table_pointer_low table_pointer_high table_latch_high bp system_mode_register interrupt_edge_select interrupt_control_zero multi_function_interrupt_zero pa pac pb pbc
  localparam logic [7:0] SFR_MASK [SFR_N] = '{
    8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'h03,
    8'hff, 8'h0f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'h7f, 8'h7f};
  localparam logic [7:0] SFR_PRESET [SFR_N] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h03, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h7f, 8'h7f};
  // Registers preset by every reset except watchdog-halt
  localparam logic [SFR_N-1:0] SFR_PRESET_EN = 16'hff81;

  // ****************************************************************
  // Other reset values and field positions
  // ****************************************************************
  localparam logic [3:0]  STACK_TOP      = 4'hf;
  localparam logic [7:0]  ANALOG_ALL     = 8'hff;
  localparam logic [15:0] WDT_LIMIT_DEF  = 16'hffff;
  localparam int BIT_TO      = 0;
  localparam int BIT_PDF     = 1;
  localparam int BIT_LOW_VOLTAGE_RESET_FLAG    = 0;
  localparam int BIT_TIMERS  = 1;
  localparam int BIT_WDT_EN  = 2;
  localparam int IRQ_W       = 4;

  // Initialization columns
  typedef enum logic [2:0] {
    COL_POR, COL_WDT_RUN, COL_EXT_RUN, COL_EXT_HALT, COL_WDT_HALT
  } rsi_col_e;

endpackage : rsi_pkg

// *** verif/rsi_src_model.sv ***
// Behavioural model of the reset sources and the core halt state
`timescale 1ns/100ps
module rsi_src_model (
  input  wire logic       aclk,
  input  wire logic [1:0] kind,
  input  wire logic       go,
  input  wire logic       halt,
  output logic            external_reset_pin_n,
  output logic            low_voltage_reset,
  output logic            usb_reset,
  output logic            core_halted
);
  logic [2:0] len_reg = 3'h0;

  // Pulse length of the selected source, held well past the synchronizer
  always @(posedge aclk) begin
    if (go)
      len_reg <= 3'h6;
    else if (len_reg != 3'h0)
      len_reg <= len_reg - 3'h1;
  end

  // Source lines: 0 pin (low active), 1 low voltage, 2 bus reset
  assign external_reset_pin_n = !(len_reg != 3'h0 && kind == 2'h0);
  assign low_voltage_reset    = len_reg != 3'h0 && kind == 2'h1;
  assign usb_reset            = len_reg != 3'h0 && kind == 2'h2;
  assign core_halted          = halt;
endmodule : rsi_src_model

// *** verif/test_reset_state_initializer.sv ***
// Self-checking bench of the reset state initializer
`timescale 1ns/100ps
module test_reset_state_initializer;
  import rsi_pkg::*;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam logic [15:0] LIM = 16'h0100;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        cen = 1'b1;
  logic        external_reset_pin_n, low_voltage_reset, usb_reset, core_halted;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        irq, core_restart, timers_on;
  logic [1:0]  src_kind = 2'h0;
  logic        src_go = 1'b0;
  logic        src_halt = 1'b0;
  logic [31:0] rdv;
  logic [1:0]  rsp;
  int          n_fail = 0;
  int          n_checks = 0;

  // 20 MHz clock
  always #25 aclk = ~aclk;

  rsi_reset_init #(.WDT_LIMIT(LIM)) dut_u (.aclk, .aresetn, .cen, .external_reset_pin_n,
    .low_voltage_reset, .usb_reset, .core_halted, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq, .core_restart,
    .timers_on);
  rsi_src_model src_u (.aclk, .kind(src_kind), .go(src_go), .halt(src_halt),
    .external_reset_pin_n, .low_voltage_reset, .usb_reset, .core_halted);

  // ****************************************************************
  // Verdict, compare and bus tasks
  // ****************************************************************
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One bounded clock step of a wait
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 500) begin
      n_fail++;
      report_and_stop();
    end
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rdv, e);
  endtask : rchk

  // ****************************************************************
  // Shared scenario steps
  // ****************************************************************
  // Scribble registers away from their presets, timers on
  task automatic prep(input logic halt);
    wr(OFS_WDT, 32'h0);
    for (int i = 0; i < SFR_N; i++)
      wr(OFS_SFR_BASE + 8'(4 * i), 32'ha5);
    wr(OFS_STACK, 32'h3);
    wr(OFS_CTRL, 32'h6);
    src_halt <= halt;
    @(posedge aclk);
    chk({31'h0, timers_on}, 32'h1);
  endtask : prep

  // Raise a source (3 waits for the watchdog) and await the restart pulse
  task automatic fire(input logic [1:0] k);
    int n;
    n = 0;
    @(posedge aclk);
    src_kind <= k;
    src_go   <= (k != 2'h3);
    @(posedge aclk);
    src_go <= 1'b0;
    do
      tick(n);
    while (!core_restart);
    @(posedge aclk);
    chk({31'h0, core_restart}, 32'h0);
  endtask : fire

  // Compare the state left by the chosen column
  task automatic post(input logic full, input logic [2:0] col);
    logic [7:0] e;
    rd(OFS_WDT);
    chk({31'h0, rdv[15:0] < 16'h0040}, 32'h1);
    chk({31'h0, timers_on}, 32'h0);
    rd(OFS_RECORD);
    chk({29'h0, rdv[6:4]}, {29'h0, col});
    chk({24'h0, rdv[15:8]}, 32'hff);
    rchk(OFS_STACK, {28'h0, STACK_TOP});
    for (int i = 0; i < SFR_N; i++) begin
      e = ((full && SFR_PRESET_EN[i]) || i == 0) ? SFR_PRESET[i] : (8'ha5 & SFR_MASK[i]);
      rchk(OFS_SFR_BASE + 8'(4 * i), {24'h0, e});
    end
  endtask : post

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_por();
    rchk(OFS_STATUS, 32'h0);
    rchk(OFS_CTRL, 32'h4);
    rchk(OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rchk(OFS_STACK, {28'h0, STACK_TOP});
    rd(OFS_RECORD);
    chk({24'h0, rdv[15:8]}, 32'hff);
    for (int i = 0; i < SFR_N; i++)
      rchk(OFS_SFR_BASE + 8'(4 * i), {24'h0, SFR_PRESET[i]});
  endtask : s_por

  task automatic s_wdt_run();
    prep(1'b0);
    fire(2'h3);
    rchk(OFS_STATUS, 32'h1);
    post(1'b1, 3'h1);
  endtask : s_wdt_run

  task automatic s_pin_run();
    prep(1'b0);
    fire(2'h0);
    rchk(OFS_STATUS, 32'h1);
    post(1'b1, 3'h2);
  endtask : s_pin_run

  task automatic s_pin_halt();
    prep(1'b1);
    fire(2'h0);
    rchk(OFS_STATUS, 32'h2);
    post(1'b1, 3'h3);
  endtask : s_pin_halt

  task automatic s_wdt_halt();
    prep(1'b1);
    fire(2'h3);
    rchk(OFS_STATUS, 32'h3);
    post(1'b0, 3'h4);
  endtask : s_wdt_halt

  task automatic s_usb_halt();
    prep(1'b1);
    fire(2'h2);
    rchk(OFS_STATUS, 32'h3);
    post(1'b1, 3'h2);
  endtask : s_usb_halt

  task automatic s_lvr();
    prep(1'b0);
    fire(2'h1);
    rchk(OFS_STATUS, 32'h3);
    post(1'b1, 3'h2);
    rchk(OFS_CTRL, 32'h5);
    wr(OFS_CTRL, 32'h5);
    rchk(OFS_CTRL, 32'h5);
    wr(OFS_CTRL, 32'h4);
    rchk(OFS_CTRL, 32'h4);
  endtask : s_lvr

  // Interrupt raise, mask, clear and an unmapped address
  task automatic s_irq();
    wr(OFS_WDT, 32'h0);
    wr(OFS_IRQ_STAT, 32'hf);
    fire(2'h0);
    rchk(OFS_IRQ_STAT, 32'h1);
    rchk(OFS_IRQ_MASK, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_IRQ_MASK, 32'h1);
    rchk(OFS_IRQ_MASK, 32'h1);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_IRQ_STAT, 32'h1);
    rchk(OFS_IRQ_STAT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(8'h3c, 32'h1);
    chk({30'h0, rsp}, 32'h2);
    rchk(8'h3c, 32'h0);
    chk({30'h0, rsp}, 32'h2);
  endtask : s_irq

  // Enable low swallows a pin pulse; a second reset clears the flags
  task automatic s_cen();
    @(posedge aclk);
    cen      <= 1'b0;
    src_kind <= 2'h0;
    src_go   <= 1'b1;
    @(posedge aclk);
    src_go <= 1'b0;
    repeat (12) @(posedge aclk);
    chk({31'h0, core_restart}, 32'h0);
    cen <= 1'b1;
    repeat (6) @(posedge aclk);
    chk({31'h0, core_restart}, 32'h0);
    rchk(OFS_IRQ_STAT, 32'h0);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(OFS_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
  endtask : s_cen

  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    s_por();
    s_wdt_run();
    s_pin_run();
    s_pin_halt();
    s_wdt_halt();
    s_usb_halt();
    s_lvr();
    s_irq();
    s_cen();
    report_and_stop();
  end

  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end
endmodule : test_reset_state_initializer
